// ---- design/pta_pkg.sv ----
// shared constants, modes and carrier types of the picture transfer accelerator
package pta_pkg;
  // register byte offsets from the block base
  localparam logic [5:0] OFF_CONTROL_ZERO = 6'h00;
  localparam logic [5:0] OFF_SOURCE_ONE_BLEND_WEIGHT = 6'h04;
  localparam logic [5:0] OFF_SOURCE_ZERO_BLEND_WEIGHT = 6'h08;
  localparam logic [5:0] OFF_GLYPH_AREA_PALETTE = 6'h0C;
  localparam logic [5:0] OFF_NON_GLYPH_AREA_PALETTE = 6'h10;
  localparam logic [5:0] OFF_SOURCE_ONE_READ_STEP = 6'h14;
  localparam logic [5:0] OFF_CONTROL_TWO = 6'h18;
  localparam logic [5:0] OFF_DEST_X_WRITE_STEP = 6'h1C;
  localparam logic [5:0] OFF_DEST_Y_WRITE_STEP = 6'h20;
  localparam logic [5:0] OFF_SOURCE_PICTURE_SIZE = 6'h24;
  localparam logic [5:0] OFF_DEST_PICTURE_SIZE = 6'h28;
  localparam logic [5:0] OFF_SOURCE_ZERO_START_ADDR = 6'h2C;
  localparam logic [5:0] OFF_DEST_START_ADDR = 6'h30;
  localparam logic [5:0] OFF_CONTROL_ONE = 6'h34;
  localparam logic [5:0] OFF_SOURCE_ZERO_READ_STEP = 6'h38;
  localparam int NUM_REGS = 15;
  // word indexes of the registers the engine reads
  localparam int IDX_CONTROL_ZERO = int'(OFF_CONTROL_ZERO >> 2);
  localparam int IDX_S1_WEIGHT = int'(OFF_SOURCE_ONE_BLEND_WEIGHT >> 2);
  localparam int IDX_S0_WEIGHT = int'(OFF_SOURCE_ZERO_BLEND_WEIGHT >> 2);
  localparam int IDX_GLYPH_PAL = int'(OFF_GLYPH_AREA_PALETTE >> 2);
  localparam int IDX_NON_GLYPH_PAL = int'(OFF_NON_GLYPH_AREA_PALETTE >> 2);
  localparam int IDX_S1_STEP = int'(OFF_SOURCE_ONE_READ_STEP >> 2);
  localparam int IDX_CONTROL_TWO = int'(OFF_CONTROL_TWO >> 2);
  localparam int IDX_DX_STEP = int'(OFF_DEST_X_WRITE_STEP >> 2);
  localparam int IDX_DY_STEP = int'(OFF_DEST_Y_WRITE_STEP >> 2);
  localparam int IDX_SRC_SIZE = int'(OFF_SOURCE_PICTURE_SIZE >> 2);
  localparam int IDX_DST_SIZE = int'(OFF_DEST_PICTURE_SIZE >> 2);
  localparam int IDX_S0_ADDR = int'(OFF_SOURCE_ZERO_START_ADDR >> 2);
  localparam int IDX_DST_ADDR = int'(OFF_DEST_START_ADDR >> 2);
  localparam int IDX_CONTROL_ONE = int'(OFF_CONTROL_ONE >> 2);
  localparam int IDX_S0_STEP = int'(OFF_SOURCE_ZERO_READ_STEP >> 2);
  // reset values
  localparam logic [31:0] RST_CONTROL_ZERO = 32'h0000_0500;
  localparam logic [31:0] RST_OTHER = 32'h0000_0000;
  // field positions
  localparam int CZ_FMT16_BIT = 10;
  localparam int CZ_S1_HI_MSB = 7;
  localparam int CO_MODE_MSB = 4;
  localparam int CO_DONE_BIT = 30;
  localparam int CO_START_BIT = 31;
  localparam int W_R_LSB = 16;
  localparam int W_G_LSB = 8;
  localparam int W_B_LSB = 0;
  localparam int SZ_W_LSB = 0;
  localparam int SZ_H_LSB = 16;
  localparam int SZ_BITS = 11;
  localparam int STEP_RATIO_LSB = 16;
  localparam int STEP_PITCH_LSB = 0;
  localparam int FRAC_BITS = 8;
  localparam int CUBIC_SHIFT = 7;
  localparam int FIFO_DEPTH = 8;

  // operating modes of the mode field
  typedef enum logic [4:0] {
    PTA_NORMAL = 5'h00,
    PTA_SCALER = 5'h01,
    PTA_MONO = 5'h02,
    PTA_MONO_INV = 5'h03,
    PTA_BLEND = 5'h04,
    PTA_MONO_BLEND = 5'h05,
    PTA_MONO_INV_BLEND = 5'h06,
    PTA_FONT_BLEND = 5'h07,
    PTA_FONT_INV_BLEND = 5'h08
  } pta_mode_t;

  // datapath units that a mode switches on
  typedef struct packed {
    logic s0;
    logic scaler;
    logic blend;
    logic mono;
    logic invert;
    logic font;
  } pta_use_t;

  // one destination write waiting in the buffer
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be;
  } pta_wr_t;

  function automatic pta_use_t pta_decode(input logic [4:0] mode);
    pta_use_t u;
    u = '0;
    case (mode)
      PTA_SCALER: u.scaler = 1'b1;
      PTA_MONO: u.mono = 1'b1;
      PTA_MONO_INV: u = '{s0: 1'b0, scaler: 1'b0, blend: 1'b0, mono: 1'b1, invert: 1'b1, font: 1'b0};
      PTA_BLEND: u = '{s0: 1'b1, scaler: 1'b0, blend: 1'b1, mono: 1'b0, invert: 1'b0, font: 1'b0};
      PTA_MONO_BLEND: u = '{s0: 1'b1, scaler: 1'b0, blend: 1'b1, mono: 1'b1, invert: 1'b0, font: 1'b0};
      PTA_MONO_INV_BLEND: u = '{s0: 1'b1, scaler: 1'b0, blend: 1'b1, mono: 1'b1, invert: 1'b1,
                                font: 1'b0};
      PTA_FONT_BLEND: u = '{s0: 1'b1, scaler: 1'b0, blend: 1'b1, mono: 1'b1, invert: 1'b0, font: 1'b1};
      PTA_FONT_INV_BLEND: u = '{s0: 1'b1, scaler: 1'b0, blend: 1'b1, mono: 1'b1, invert: 1'b1,
                                font: 1'b1};
      default: u = '0;
    endcase
    return u;
  endfunction
endpackage

// ---- design/pta_fifo.sv ----
// parameterised valid/ready fifo for pending destination writes
`timescale 1ns/1ps
module pta_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic full;
  logic empty;

  // extra pointer bit tells full from empty
  assign empty = (wr_q == rd_q);
  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem_q[rd_q[AW-1:0]];

  // storage
  always_ff @(posedge i_clk) begin
    if (i_in_valid && !full) begin
      mem_q[wr_q[AW-1:0]] <= i_in_data;
    end
  end

  // pointers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (i_in_valid && !full) begin
        wr_q <= wr_q + 1'b1;
      end
      if (i_out_ready && !empty) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// ---- design/pta_picture_accelerator.sv ----
// register bank, pixel engine and memory port of the picture transfer accelerator
`timescale 1ns/1ps
// What this block does
// - scaler mode: horizontal cubic resampling of source one, source zero and blender idle
// - monochrome mode: colorize source one bits, copy or thin, no expander/blender
// - monochrome invert: same as monochrome with the two palette colors swapped
// - blend mode: blend two 16 or 24 bpp color sources, no expander
// - monochrome blend: colorize source one, blend with source zero color
// - monochrome invert blend: like monochrome blend with palette colors swapped
// - font blend: only source one ones are blended, rest copies source zero
// - font invert blend: only source one zeros are blended, glyphs keep source zero
// - non-scaler modes shrink by dropping pixels; address stepping always active
// - registers sit on a 32-bit cpu bus at byte offsets from a base
// - separate blend weight registers for source one and source zero
// - two source one palette registers: glyph color and non-glyph color
// - destination x/y write steps and per-source read steps come from registers
// - picture sizes and source zero/destination start addresses come from their own registers; source one base from control zero bits 7:0
// - a five-bit mode field selects the mode and sets the datapath
// - blender weights each 8-bit channel out of 256 and adds both
module pta_picture_accelerator (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [5:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_wdata,
  output logic [3:0] o_mem_be,
  input wire logic i_mem_gnt,
  input wire logic i_mem_rvalid,
  input wire logic [31:0] i_mem_rdata,
  output logic o_busy,
  output logic o_done
);
  import pta_pkg::*;

  typedef enum logic [2:0] {
    E_IDLE = 3'b000, E_RD1 = 3'b001, E_RD0 = 3'b011, E_CALC = 3'b010,
    E_PUSH = 3'b110, E_NEXT = 3'b111, E_DRAIN = 3'b101
  } pta_eng_t;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00, M_RGNT = 2'b01, M_RDAT = 2'b11, M_WGNT = 2'b10
  } pta_mem_t;

  logic [31:0] regs_q [NUM_REGS];
  logic [3:0] widx;
  logic wsel;
  logic start;
  pta_eng_t eng_q;
  pta_mem_t mem_q;
  logic half_q;
  logic rd_done;
  logic rd_want;
  logic [31:0] rd_addr_c;
  logic rd_half_c;
  pta_use_t use_c;
  logic fmt16;
  logic [10:0] src_w;
  logic [10:0] dst_w;
  logic [10:0] dst_h;
  logic [10:0] dx_q;
  logic [10:0] dy_q;
  logic [18:0] sx_q;
  logic [18:0] sy_q;
  logic [1:0] tap_q;
  logic signed [19:0] acc_q [3];
  logic [23:0] s1_pix_q;
  logic [23:0] s0_pix_q;
  logic s1_bit_q;
  logic [23:0] out_q;
  logic [31:0] drow_q;
  logic [31:0] dpix_q;
  logic [23:0] rd_pix;
  pta_wr_t fifo_in;
  pta_wr_t fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;

  // unpack a 565 or 888 pixel out of a bus word
  function automatic logic [23:0] pta_unpack(input logic [31:0] w, input logic hi,
                                              input logic f16);
    logic [15:0] h;
    h = hi ? w[31:16] : w[15:0];
    if (f16) begin
      return {h[15:11], h[15:13], h[10:5], h[10:9], h[4:0], h[4:2]};
    end
    return w[23:0];
  endfunction

  // one blender channel: weights out of 256, sum may wrap above 0xFF
  function automatic logic [7:0] pta_mix(input logic [7:0] c0, input logic [7:0] c1,
                                         input logic [7:0] w0, input logic [7:0] w1);
    logic [16:0] s;
    s = 17'(c0 * w0) + 17'(c1 * w1);
    return s[15:8];
  endfunction

  // catmull-rom tap weight in 1/128 steps for quarter-pixel phases
  function automatic logic signed [8:0] pta_tap(input logic [1:0] ph, input logic [1:0] t);
    logic signed [8:0] w;
    w = 9'sd0;
    case ({ph, t})
      4'h1: w = 9'sd128;
      4'h4: w = -9'sd9;
      4'h5: w = 9'sd111;
      4'h6: w = 9'sd29;
      4'h7: w = -9'sd3;
      4'h8: w = -9'sd8;
      4'h9: w = 9'sd72;
      4'hA: w = 9'sd72;
      4'hB: w = -9'sd8;
      4'hC: w = -9'sd3;
      4'hD: w = 9'sd29;
      4'hE: w = 9'sd111;
      4'hF: w = -9'sd9;
      default: w = 9'sd0;
    endcase
    return w;
  endfunction

  // clamp an interpolated sum back to one 8-bit channel
  function automatic logic [7:0] pta_clamp(input logic signed [19:0] a);
    logic signed [19:0] v;
    v = a >>> CUBIC_SHIFT;
    if (v < 0) begin
      return 8'h00;
    end
    if (v > 20'sd255) begin
      return 8'hFF;
    end
    return v[7:0];
  endfunction

  assign widx = i_reg_addr[5:2];
  assign wsel = (i_reg_addr[1:0] == 2'b00) && (int'(widx) < NUM_REGS);
  assign start = i_reg_wr && wsel && (int'(widx) == IDX_CONTROL_ONE) &&
                 i_reg_wdata[CO_START_BIT] && (eng_q == E_IDLE);

  // register bank, one word per register
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < NUM_REGS; i++) begin
      if (i_sys_rst) begin
        regs_q[i] <= (i == IDX_CONTROL_ZERO) ? RST_CONTROL_ZERO : RST_OTHER;
      end else if (i_reg_wr && wsel && int'(widx) == i) begin
        regs_q[i] <= (i == IDX_CONTROL_ONE) ? {2'b00, i_reg_wdata[29:0]} : i_reg_wdata;
      end
    end
  end

  // read data, status overlaid on control one, unmapped reads zero
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      if (!wsel) begin
        o_reg_rdata <= '0;
      end else if (int'(widx) == IDX_CONTROL_ONE) begin
        o_reg_rdata <= {o_busy, o_done, regs_q[IDX_CONTROL_ONE][29:0]};
      end else begin
        o_reg_rdata <= regs_q[widx];
      end
    end
  end

  // sticky done, engine completion wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_done <= 1'b0;
    end else if (eng_q == E_DRAIN && !fifo_out_valid && mem_q == M_IDLE) begin
      o_done <= 1'b1;
    end else if (i_reg_wr && wsel && int'(widx) == IDX_CONTROL_ONE &&
                 i_reg_wdata[CO_DONE_BIT]) begin
      o_done <= 1'b0;
    end
  end

  // mode field picks the datapath units
  assign use_c = pta_decode(regs_q[IDX_CONTROL_ONE][CO_MODE_MSB:0]);
  assign fmt16 = regs_q[IDX_CONTROL_ZERO][CZ_FMT16_BIT];
  assign src_w = regs_q[IDX_SRC_SIZE][SZ_W_LSB +: SZ_BITS];
  assign dst_w = regs_q[IDX_DST_SIZE][SZ_W_LSB +: SZ_BITS];
  assign dst_h = regs_q[IDX_DST_SIZE][SZ_H_LSB +: SZ_BITS];

  // read address of the current source fetch
  always_comb begin
    logic signed [12:0] tx;
    logic [10:0] cx;
    logic [31:0] base;
    logic [31:0] pitch;
    logic [31:0] offs;
    tx = $signed({2'b00, sx_q[18:8]}) + $signed({11'b0, tap_q}) - 13'sd1;
    cx = sx_q[18:8];
    base = {regs_q[IDX_CONTROL_ZERO][CZ_S1_HI_MSB:0], 24'h00_0000};
    pitch = 32'(regs_q[IDX_S1_STEP][STEP_PITCH_LSB +: 16]);
    offs = '0;
    // four neighbouring taps, clamped to the picture edge
    if (use_c.scaler) begin
      if (tx < 0) begin
        cx = '0;
      end else if (tx >= $signed({2'b00, src_w})) begin
        cx = src_w - 11'd1;
      end else begin
        cx = tx[10:0];
      end
    end
    // row pitch from the per-source read step
    if (eng_q == E_RD0) begin
      base = regs_q[IDX_S0_ADDR];
      pitch = 32'(regs_q[IDX_S0_STEP][STEP_PITCH_LSB +: 16]);
    end
    if (use_c.mono && eng_q != E_RD0) begin
      offs = {24'h00_0000, cx[10:5], 2'b00};
    end else begin
      offs = fmt16 ? {20'h0_0000, cx, 1'b0} : {19'h0_0000, cx, 2'b00};
    end
    rd_addr_c = base + 32'(sy_q[18:8]) * pitch + offs;
    rd_half_c = rd_addr_c[1];
  end

  assign rd_want = (eng_q == E_RD1) || (eng_q == E_RD0);
  assign rd_done = (mem_q == M_RDAT) && i_mem_rvalid;
  assign rd_pix = pta_unpack(i_mem_rdata, half_q, fmt16);
  assign fifo_pop = (mem_q == M_WGNT) && i_mem_gnt;

  // memory port: engine reads first, buffered writes when engine waits
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mem_q <= M_IDLE;
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= '0;
      o_mem_wdata <= '0;
      o_mem_be <= '0;
      half_q <= 1'b0;
    end else begin
      unique case (mem_q)
        M_IDLE: begin
          if (rd_want) begin
            o_mem_req <= 1'b1;
            o_mem_we <= 1'b0;
            o_mem_addr <= {rd_addr_c[31:2], 2'b00};
            o_mem_be <= 4'hF;
            half_q <= rd_half_c;
            mem_q <= M_RGNT;
          end else if (fifo_out_valid) begin
            o_mem_req <= 1'b1;
            o_mem_we <= 1'b1;
            o_mem_addr <= fifo_out.addr;
            o_mem_wdata <= fifo_out.data;
            o_mem_be <= fifo_out.be;
            mem_q <= M_WGNT;
          end
        end
        M_RGNT: begin
          if (i_mem_gnt) begin
            o_mem_req <= 1'b0;
            mem_q <= M_RDAT;
          end
        end
        M_RDAT: begin
          if (i_mem_rvalid) begin
            mem_q <= M_IDLE;
          end
        end
        M_WGNT: begin
          if (i_mem_gnt) begin
            o_mem_req <= 1'b0;
            o_mem_we <= 1'b0;
            mem_q <= M_IDLE;
          end
        end
      endcase
    end
  end

  // pixel engine sequencing and fetch capture
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      eng_q <= E_IDLE;
      tap_q <= '0;
      s1_pix_q <= '0;
      s0_pix_q <= '0;
      s1_bit_q <= 1'b0;
      for (int c = 0; c < 3; c++) begin
        acc_q[c] <= '0;
      end
    end else begin
      unique case (eng_q)
        E_IDLE: begin
          tap_q <= '0;
          for (int c = 0; c < 3; c++) begin
            acc_q[c] <= '0;
          end
          if (start) begin
            eng_q <= E_RD1;
          end
        end
        E_RD1: begin
          if (rd_done) begin
            s1_pix_q <= rd_pix;
            s1_bit_q <= i_mem_rdata[sx_q[12:8]];
            // weighted tap sum for the horizontal cubic expander
            for (int c = 0; c < 3; c++) begin
              acc_q[c] <= acc_q[c] + 20'(pta_tap(sx_q[7:6], tap_q) *
                                         $signed({1'b0, rd_pix[8*c +: 8]}));
            end
            if (use_c.scaler && tap_q != 2'd3) begin
              tap_q <= tap_q + 2'd1;
            end else begin
              // source zero fetched only when the mode needs it
              eng_q <= use_c.s0 ? E_RD0 : E_CALC;
            end
          end
        end
        E_RD0: begin
          if (rd_done) begin
            s0_pix_q <= rd_pix;
            eng_q <= E_CALC;
          end
        end
        E_CALC: eng_q <= E_PUSH;
        E_PUSH: begin
          if (fifo_in_ready) begin
            eng_q <= E_NEXT;
          end
        end
        E_NEXT: begin
          tap_q <= '0;
          for (int c = 0; c < 3; c++) begin
            acc_q[c] <= '0;
          end
          eng_q <= (dx_q == dst_w - 11'd1 && dy_q == dst_h - 11'd1) ? E_DRAIN : E_RD1;
        end
        E_DRAIN: begin
          if (!fifo_out_valid && mem_q == M_IDLE) begin
            eng_q <= E_IDLE;
          end
        end
        default: eng_q <= E_IDLE;
      endcase
    end
  end

  // output pixel: colorize, interpolate or blend as the mode says
  always_ff @(posedge i_clk) begin
    logic [23:0] c1;
    logic [23:0] pal_g;
    logic [23:0] pal_n;
    logic [31:0] w0;
    logic [31:0] w1;
    logic sel;
    pal_g = regs_q[IDX_GLYPH_PAL][23:0];
    pal_n = regs_q[IDX_NON_GLYPH_PAL][23:0];
    w0 = regs_q[IDX_S0_WEIGHT];
    w1 = regs_q[IDX_S1_WEIGHT];
    c1 = s1_pix_q;
    // palette choice per source one bit
    // invert swaps the two palette colors except in font invert blend
    if (use_c.mono) begin
      c1 = (s1_bit_q ^ (use_c.invert && !use_c.font)) ? pal_g : pal_n;
    end else if (use_c.scaler) begin
      c1 = {pta_clamp(acc_q[2]), pta_clamp(acc_q[1]), pta_clamp(acc_q[0])};
    end
    // zeros blended in font invert blend
    sel = use_c.font ? (s1_bit_q ^ use_c.invert) : 1'b1;
    if (i_sys_rst) begin
      out_q <= '0;
    end else if (eng_q == E_CALC) begin
      // two color sources meet in the blender
      // colorized source one against source zero
      if (use_c.blend && sel) begin
        out_q <= {pta_mix(s0_pix_q[23:16], c1[23:16], w0[W_R_LSB +: 8], w1[W_R_LSB +: 8]),
                  pta_mix(s0_pix_q[15:8], c1[15:8], w0[W_G_LSB +: 8], w1[W_G_LSB +: 8]),
                  pta_mix(s0_pix_q[7:0], c1[7:0], w0[W_B_LSB +: 8], w1[W_B_LSB +: 8])};
      end else if (use_c.blend) begin
        out_q <= s0_pix_q;
      end else begin
        out_q <= c1;
      end
    end
  end

  // pixel dropping through fixed-point source stepping
  // destination walk with signed x/y write steps
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dx_q <= '0;
      dy_q <= '0;
      sx_q <= '0;
      sy_q <= '0;
      drow_q <= '0;
      dpix_q <= '0;
    end else if (start) begin
      dx_q <= '0;
      dy_q <= '0;
      sx_q <= '0;
      sy_q <= '0;
      drow_q <= regs_q[IDX_DST_ADDR];
      dpix_q <= regs_q[IDX_DST_ADDR];
    end else if (eng_q == E_NEXT) begin
      if (dx_q == dst_w - 11'd1) begin
        dx_q <= '0;
        dy_q <= dy_q + 11'd1;
        sx_q <= '0;
        sy_q <= sy_q + 19'(regs_q[IDX_CONTROL_TWO][15:0]);
        drow_q <= drow_q + regs_q[IDX_DY_STEP];
        dpix_q <= drow_q + regs_q[IDX_DY_STEP];
      end else begin
        dx_q <= dx_q + 11'd1;
        sx_q <= sx_q + 19'(regs_q[IDX_S1_STEP][STEP_RATIO_LSB +: 16]);
        dpix_q <= dpix_q + regs_q[IDX_DX_STEP];
      end
    end
  end

  // pack the output pixel into a bus write
  always_comb begin
    logic [15:0] p565;
    p565 = {out_q[23:19], out_q[15:10], out_q[7:3]};
    fifo_in.addr = {dpix_q[31:2], 2'b00};
    if (fmt16) begin
      fifo_in.data = {p565, p565};
      fifo_in.be = dpix_q[1] ? 4'hC : 4'h3;
    end else begin
      fifo_in.data = {8'h00, out_q};
      fifo_in.be = 4'hF;
    end
  end

  // busy from start until the last write has left
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_busy <= 1'b0;
    end else if (start) begin
      o_busy <= 1'b1;
    end else if (eng_q == E_DRAIN && !fifo_out_valid && mem_q == M_IDLE) begin
      o_busy <= 1'b0;
    end
  end

  pta_fifo #(
    .WIDTH($bits(pta_wr_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(eng_q == E_PUSH),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out)
  );
endmodule

// ---- bench/pta_mem_model.sv ----
// system memory partner answering the accelerator memory port
`timescale 1ns/1ps
module pta_mem_model (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_be,
  output logic o_gnt = 1'b0,
  output logic o_rvalid = 1'b0,
  output logic [31:0] o_rdata = 32'h0
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0] wait_q = 2'h0;
  logic [1:0] rcnt_q = 2'h0;
  logic slow_q = 1'b0;
  logic [31:0] rd_q = 32'h0;
  // grant after none or three waits, alternating; read data two cycles later
  always @(posedge i_clk) begin
    o_gnt <= 1'b0;
    if (i_req && o_gnt) begin
      slow_q <= ~slow_q;
      wait_q <= 2'h0;
      if (i_we) begin
        for (int b = 0; b < 4; b++) if (i_be[b]) mem[i_addr][8*b+:8] = i_wdata[8*b+:8];
      end else begin
        rd_q <= mem.exists(i_addr) ? mem[i_addr] : ~i_addr;
        rcnt_q <= 2'h2;
      end
    end else if (i_req) begin
      if (wait_q == (slow_q ? 2'h3 : 2'h0)) o_gnt <= 1'b1;
      else wait_q <= wait_q + 2'h1;
    end
    if (rcnt_q != 2'h0) rcnt_q <= rcnt_q - 2'h1;
    o_rvalid <= rcnt_q == 2'h1;
    // released data lines show the inverse of the last value
    o_rdata <= (rcnt_q == 2'h1) ? rd_q : ~o_rdata;
  end
endmodule

// ---- bench/pta_chk.sv ----
// port assertions of the picture transfer accelerator
`timescale 1ns/1ps
module pta_chk (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [5:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic [31:0] o_reg_rdata,
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic [31:0] o_mem_addr,
  input wire logic [3:0] o_mem_be,
  input wire logic i_mem_gnt,
  input wire logic o_busy,
  input wire logic o_done
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  AST_REQ_HOLD: assert property (o_mem_req && !i_mem_gnt |=>
    o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we)) else $error("request moved");
  AST_REQ_DROP: assert property (o_mem_req && i_mem_gnt |=> !o_mem_req)
    else $error("request held after grant");
  AST_START_BUSY: assert property (i_reg_wr && i_reg_addr == 6'h34 && i_reg_wdata[31]
    && !o_busy |=> o_busy) else $error("start did not raise busy");
  AST_DONE_AT_END: assert property ($rose(o_done) |-> $fell(o_busy))
    else $error("done without end of job");
  AST_IDLE_QUIET: assert property (!o_busy |-> !o_mem_req)
    else $error("memory request while idle");
  AST_READ_BE: assert property (o_mem_req && !o_mem_we |-> o_mem_be == 4'hF)
    else $error("read lanes not full");
  AST_WORD_ALIGN: assert property (o_mem_req |-> o_mem_addr[1:0] == 2'h0)
    else $error("unaligned memory address");
  AST_RDATA_STANDS: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without read");
  AST_UNMAPPED_ZERO: assert property (i_reg_rd && i_reg_addr > 6'h38 |=>
    o_reg_rdata == 32'h0) else $error("unmapped read not zero");
  // main scenarios
  cover property (!o_busy ##1 o_busy);
  cover property (o_mem_req && !o_mem_we && i_mem_gnt);
  cover property (o_mem_req && o_mem_we && i_mem_gnt);
endmodule
bind pta_picture_accelerator pta_chk i_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_mem_req(o_mem_req),
  .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_be(o_mem_be),
  .i_mem_gnt(i_mem_gnt), .o_busy(o_busy), .o_done(o_done));

// ---- bench/pta_picture_accelerator_tb.sv ----
// self-checking bench for the picture transfer accelerator
`timescale 1ns/1ps
module pta_picture_accelerator_tb;
  import pta_pkg::*;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [5:0] i_reg_addr = 6'h00;
  logic [31:0] i_reg_wdata = 32'h0;
  logic [31:0] o_reg_rdata, addr, wdata, rdata;
  logic req, we, gnt, rvalid, o_busy, o_done;
  logic [3:0] be;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  // register image: 24 bpp, 2x1 pictures, weights 0x80 and 0x7F
  logic [31:0] cfg [15] = '{32'h1, 32'h7F7F7F, 32'h808080, 32'hF01008, 32'h830E0,
    32'h100_0008, 32'h100, 32'h4, 32'h8, 32'h1_0002, 32'h1_0002, 32'h300_0000,
    32'h200_0000, 32'h0, 32'h100_0008};
  logic [23:0] s1c [2] = '{24'h000001, 24'hC0A080};
  logic [23:0] s0c [2] = '{24'h204060, 24'h6080A0};
  always #12.5 i_clk = ~i_clk;
  pta_picture_accelerator i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_mem_req(req), .o_mem_we(we), .o_mem_addr(addr),
    .o_mem_wdata(wdata), .o_mem_be(be), .i_mem_gnt(gnt), .i_mem_rvalid(rvalid),
    .i_mem_rdata(rdata), .o_busy(o_busy), .o_done(o_done));
  pta_mem_model i_mem (.i_clk(i_clk), .i_req(req), .i_we(we), .i_addr(addr),
    .i_wdata(wdata), .i_be(be), .o_gnt(gnt), .o_rvalid(rvalid), .o_rdata(rdata));
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    tick();
    i_reg_wr = 1'b0;
    tick();
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    tick();
    i_reg_rd = 1'b0;
    d = o_reg_rdata;
    tick();
  endtask
  // per channel weighted sum out of 256
  function automatic logic [23:0] mix(input logic [23:0] c0, input logic [23:0] c1);
    logic [23:0] r;
    for (int k = 0; k < 24; k += 8) r[k+:8] = 8'((c0[k+:8] * 16'h80 + c1[k+:8] * 16'h7F) >> 8);
    return r;
  endfunction
  // expected destination pixel; source one bit is set at x 0 only
  function automatic logic [23:0] pix(input int m, input int x);
    logic b;
    logic [23:0] g, n;
    b = (x == 0);
    g = b ? cfg[3][23:0] : cfg[4][23:0];
    n = b ? cfg[4][23:0] : cfg[3][23:0];
    case (m)
      2: return g;
      3: return n;
      4: return mix(s0c[x], s1c[x]);
      5: return mix(s0c[x], g);
      6: return mix(s0c[x], n);
      7: return b ? mix(s0c[x], g) : s0c[x];
      8: return b ? s0c[x] : mix(s0c[x], cfg[4][23:0]);
      default: return s1c[x];
    endcase
  endfunction
  task automatic test_regs();
    logic [31:0] v;
    for (int k = 0; k < 16; k++) begin
      rd(6'(k * 4), v);
      check("reset value", (k == 0) ? RST_CONTROL_ZERO : RST_OTHER, v);
    end
    for (int k = 0; k < 15; k++) begin
      if (k != 13) wr(6'(k * 4), cfg[k]);
      if (k != 13) rd(6'(k * 4), v);
      if (k != 13) check("readback", cfg[k], v);
    end
    $display("test registers done");
  endtask
  task automatic test_modes();
    logic [31:0] v;
    for (int m = 0; m < 9; m++) begin
      for (int x = 0; x < 2; x++) i_mem.mem[32'h200_0000 + 4 * x] = 32'hDEAD_BEEF;
      wr(6'h34, 32'h8000_0000 | 32'(m));
      check("busy", 32'h1, {31'h0, o_busy});
      for (int n = 0; n < 3000 && o_done !== 1'b1; n++) tick();
      rd(6'h34, v);
      check("status", 32'h4000_0000 | 32'(m), v);
      for (int x = 0; x < 2; x++)
        check("pixel", pix(m, x), i_mem.mem[32'h200_0000 + 4 * x] & 32'hFF_FFFF);
      wr(6'h34, 32'h4000_0000 | 32'(m));
      check("done cleared", 32'h0, {31'h0, o_done});
    end
    $display("test modes done");
  endtask
  task automatic complete_run();
    $display("counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    i_mem.mem[32'h100_0000] = 32'h1;
    i_mem.mem[32'h100_0004] = 32'hC0A080;
    i_mem.mem[32'h300_0000] = 32'h204060;
    i_mem.mem[32'h300_0004] = 32'h6080A0;
    repeat (12) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    tick();
    test_regs();
    test_modes();
    complete_run();
  end
endmodule
